// file: core/boot_order_map.svh
`ifndef BOOT_ORDER_MAP_SVH
`define BOOT_ORDER_MAP_SVH

// Strap width and the longest boot order that any table holds.
`define STRAP_WIDTH      6
`define ORDER_SLOTS      4
// Time in ns that a source may take to answer a probe before it counts as empty.
`define PROBE_TIMEOUT_NS 20480
`define CLK_PERIOD_NS    20
`define PROBE_TIMEOUT_CYC ((`PROBE_TIMEOUT_NS) / (`CLK_PERIOD_NS))
// Position of the top strap bit, which picks the peripheral or memory group.
`define STRAP_TOP_BIT    5
// Code that the board straps by default.
`define STRAP_DEFAULT    6'h0C
// Code for the fast execute-in-place path.
`define STRAP_FAST_XIP   6'h1F

`endif

// file: core/boot_order_pkg.sv
package boot_order_pkg;

   // Boot sources; the code is also the index of the probe lines.
   typedef enum logic [3:0] {
      SRC_NONE        = 4'h0,
      SRC_NAND        = 4'h1,
      SRC_ETHERNET    = 4'h2,
      SRC_USB         = 4'h3,
      SRC_CARD_ONE    = 4'h4,
      SRC_CARD_TWO    = 4'h5,
      SRC_UART        = 4'h6,
      SRC_SPI         = 4'h7,
      SRC_XIP_FLASH   = 4'h8,
      SRC_DISK_ONCHIP = 4'h9,
      SRC_XIP_WAIT    = 4'hA,
      SRC_SERIAL_3    = 4'hB
   } boot_src_t;

   typedef enum logic [2:0] {
      ST_CAPTURE = 3'b000,
      ST_LOOKUP  = 3'b001,
      ST_PROBE   = 3'b010,
      ST_BOOTED  = 3'b011,
      ST_FAILED  = 3'b100
   } walk_state_t;

endpackage : boot_order_pkg

// file: core/boot_order_table.sv
`timescale 1ns/100ps
`include "boot_order_map.svh"

// Decode tables held as a registered lookup, one source per slot.
module boot_order_table (
   // Clock and reset.
   input  wire logic                      core_clk,
   input  wire logic                      resetn,
   // Lookup request.
   input  wire logic [`STRAP_WIDTH-1:0]   strapCode,
   input  wire logic                      warmBoot,
   input  wire logic [1:0]                slot,
   // Registered answer.
   output boot_order_pkg::boot_src_t      srcOut,
   output logic                           memPrefOut
);
   import boot_order_pkg::*;

   boot_src_t srcOut_ff;
   boot_src_t nxt_srcOut;
   logic      memPref_ff;
   logic      nxt_memPref;

   function automatic boot_src_t pick(input logic [1:0] s,
      input boot_src_t a, input boot_src_t b,
      input boot_src_t c, input boot_src_t d);
      case (s)
         2'd0:    pick = a;
         2'd1:    pick = b;
         2'd2:    pick = c;
         default: pick = d;
      endcase
   endfunction : pick

   always_comb begin
      nxt_srcOut  = SRC_NONE;
      nxt_memPref = 1'b0;
      if (strapCode == `STRAP_FAST_XIP) begin
         nxt_srcOut  = pick(slot, SRC_XIP_WAIT, SRC_USB, SRC_SERIAL_3,
                            SRC_NONE);
         nxt_memPref = 1'b1;
      end else if (!warmBoot) begin
         unique case (strapCode)
            6'h01: nxt_srcOut = pick(slot, SRC_NAND, SRC_ETHERNET, SRC_USB,
                                     SRC_NONE);
            6'h03: nxt_srcOut = pick(slot, SRC_CARD_TWO, SRC_ETHERNET,
                                     SRC_USB, SRC_NONE);
            6'h05: nxt_srcOut = pick(slot, SRC_CARD_TWO, SRC_USB, SRC_NONE,
                                     SRC_NONE);
            6'h06: nxt_srcOut = pick(slot, SRC_CARD_ONE, SRC_USB, SRC_NONE,
                                     SRC_NONE);
            6'h07: nxt_srcOut = pick(slot, SRC_XIP_FLASH, SRC_ETHERNET,
                                     SRC_USB, SRC_NONE);
            6'h08: nxt_srcOut = pick(slot, SRC_DISK_ONCHIP, SRC_ETHERNET,
                                     SRC_USB, SRC_NONE);
            6'h09: nxt_srcOut = pick(slot, SRC_CARD_TWO, SRC_ETHERNET,
                                     SRC_USB, SRC_NONE);
            6'h0A: nxt_srcOut = pick(slot, SRC_XIP_FLASH, SRC_ETHERNET,
                                     SRC_USB, SRC_CARD_ONE);
            6'h0B: nxt_srcOut = pick(slot, SRC_DISK_ONCHIP, SRC_ETHERNET,
                                     SRC_USB, SRC_CARD_ONE);
            6'h0C: nxt_srcOut = pick(slot, SRC_NAND, SRC_ETHERNET, SRC_USB,
                                     SRC_CARD_ONE);
            6'h0D: nxt_srcOut = pick(slot, SRC_XIP_FLASH, SRC_USB, SRC_UART,
                                     SRC_CARD_ONE);
            6'h0E: nxt_srcOut = pick(slot, SRC_DISK_ONCHIP, SRC_USB,
                                     SRC_UART, SRC_CARD_ONE);
            6'h0F: nxt_srcOut = pick(slot, SRC_NAND, SRC_USB, SRC_UART,
                                     SRC_CARD_ONE);
            6'h11: nxt_srcOut = pick(slot, SRC_CARD_TWO, SRC_USB, SRC_UART,
                                     SRC_CARD_ONE);
            6'h12: nxt_srcOut = pick(slot, SRC_CARD_ONE, SRC_USB, SRC_UART,
                                     SRC_NONE);
            6'h13: nxt_srcOut = pick(slot, SRC_XIP_FLASH, SRC_UART,
                                     SRC_NONE, SRC_NONE);
            6'h14: nxt_srcOut = pick(slot, SRC_DISK_ONCHIP, SRC_UART,
                                     SRC_NONE, SRC_NONE);
            6'h15: nxt_srcOut = pick(slot, SRC_NAND, SRC_UART, SRC_NONE,
                                     SRC_NONE);
            6'h17: nxt_srcOut = pick(slot, SRC_CARD_TWO, SRC_UART, SRC_NONE,
                                     SRC_NONE);
            6'h18: nxt_srcOut = pick(slot, SRC_CARD_ONE, SRC_UART, SRC_NONE,
                                     SRC_NONE);
            6'h19: nxt_srcOut = pick(slot, SRC_XIP_FLASH, SRC_USB, SRC_NONE,
                                     SRC_NONE);
            6'h1A: nxt_srcOut = pick(slot, SRC_DISK_ONCHIP, SRC_USB,
                                     SRC_NONE, SRC_NONE);
            6'h1B: nxt_srcOut = pick(slot, SRC_NAND, SRC_USB, SRC_NONE,
                                     SRC_NONE);
            6'h1C: nxt_srcOut = pick(slot, SRC_SPI, SRC_UART, SRC_NONE,
                                     SRC_NONE);
            default: nxt_srcOut = SRC_NONE;
         endcase
      end else begin
         unique case (strapCode)
            6'h21: nxt_srcOut = pick(slot, SRC_ETHERNET, SRC_USB, SRC_NAND,
                                     SRC_NONE);
            6'h23: nxt_srcOut = pick(slot, SRC_ETHERNET, SRC_USB,
                                     SRC_CARD_ONE, SRC_CARD_TWO);
            6'h25: nxt_srcOut = pick(slot, SRC_USB, SRC_CARD_TWO, SRC_NONE,
                                     SRC_NONE);
            6'h26: nxt_srcOut = pick(slot, SRC_USB, SRC_CARD_ONE, SRC_NONE,
                                     SRC_NONE);
            6'h27: nxt_srcOut = pick(slot, SRC_ETHERNET, SRC_USB,
                                     SRC_XIP_FLASH, SRC_NONE);
            6'h28: nxt_srcOut = pick(slot, SRC_USB, SRC_DISK_ONCHIP,
                                     SRC_NONE, SRC_NONE);
            6'h29: nxt_srcOut = pick(slot, SRC_ETHERNET, SRC_USB,
                                     SRC_CARD_TWO, SRC_NONE);
            6'h2A: nxt_srcOut = pick(slot, SRC_ETHERNET, SRC_USB,
                                     SRC_CARD_ONE, SRC_XIP_FLASH);
            6'h2B: nxt_srcOut = pick(slot, SRC_ETHERNET, SRC_USB,
                                     SRC_CARD_ONE, SRC_DISK_ONCHIP);
            6'h2C: nxt_srcOut = pick(slot, SRC_ETHERNET, SRC_USB,
                                     SRC_CARD_ONE, SRC_NAND);
            6'h2D: nxt_srcOut = pick(slot, SRC_USB, SRC_UART, SRC_CARD_ONE,
                                     SRC_XIP_FLASH);
            6'h2E: nxt_srcOut = pick(slot, SRC_USB, SRC_UART, SRC_CARD_ONE,
                                     SRC_DISK_ONCHIP);
            6'h2F: nxt_srcOut = pick(slot, SRC_USB, SRC_UART, SRC_CARD_ONE,
                                     SRC_NAND);
            6'h31: nxt_srcOut = pick(slot, SRC_USB, SRC_UART, SRC_CARD_ONE,
                                     SRC_CARD_TWO);
            6'h32: nxt_srcOut = pick(slot, SRC_USB, SRC_UART, SRC_CARD_ONE,
                                     SRC_NONE);
            6'h33: nxt_srcOut = pick(slot, SRC_UART, SRC_XIP_FLASH,
                                     SRC_NONE, SRC_NONE);
            6'h34: nxt_srcOut = pick(slot, SRC_UART, SRC_DISK_ONCHIP,
                                     SRC_NONE, SRC_NONE);
            6'h35: nxt_srcOut = pick(slot, SRC_UART, SRC_NAND, SRC_NONE,
                                     SRC_NONE);
            6'h37: nxt_srcOut = pick(slot, SRC_UART, SRC_CARD_TWO, SRC_NONE,
                                     SRC_NONE);
            6'h38: nxt_srcOut = pick(slot, SRC_UART, SRC_CARD_ONE, SRC_NONE,
                                     SRC_NONE);
            6'h39: nxt_srcOut = pick(slot, SRC_USB, SRC_XIP_FLASH, SRC_NONE,
                                     SRC_NONE);
            6'h3A: nxt_srcOut = pick(slot, SRC_USB, SRC_DISK_ONCHIP,
                                     SRC_NONE, SRC_NONE);
            6'h3B: nxt_srcOut = pick(slot, SRC_USB, SRC_NAND, SRC_NONE,
                                     SRC_NONE);
            6'h3C: nxt_srcOut = pick(slot, SRC_UART, SRC_SPI, SRC_NONE,
                                     SRC_NONE);
            6'h3F: nxt_srcOut = pick(slot, SRC_XIP_WAIT, SRC_USB,
                                     SRC_SERIAL_3, SRC_NONE);
            default: nxt_srcOut = SRC_NONE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         srcOut_ff  <= SRC_NONE;
         memPref_ff <= 1'b0;
      end else begin
         srcOut_ff  <= nxt_srcOut;
         memPref_ff <= nxt_memPref;
      end
   end

   assign srcOut     = srcOut_ff;
   assign memPrefOut = memPref_ff;

endmodule : boot_order_table

// file: core/boot_order_strap_decoder.sv
// Notes on behaviour
// - The six strap pins are caught at reset and pick the boot order.
// - Each source is probed in order and the first with a valid image boots.
// - A source without a valid image makes the walk move to the next one.
// - After power-on, codes 01, 03 and 05 map to their listed orders.
// - After power-on, code 0D maps to flash in place, USB, UART, card one.
// - Code 1F tries fast flash in place with wait, USB, then serial three.
// - After warm reset a second table applies, with codes 21 and 3C listed.
// - Code 1F flags the fast flash-in-place memory path.
`timescale 1ns/100ps
`include "boot_order_map.svh"

module boot_order_strap_decoder #(
   parameter int PROBE_TIMEOUT = `PROBE_TIMEOUT_CYC
) (
   // Clock and reset.
   input  wire logic                     core_clk,
   input  wire logic                     resetn,
   // Board straps and reset kind.
   input  wire logic [`STRAP_WIDTH-1:0]  strapPins,
   input  wire logic                     warmReset,
   // Probe handshake with the boot sources.
   output logic                          probeReq,
   output boot_order_pkg::boot_src_t     probeSrc,
   input  wire logic                     probeDone,
   input  wire logic                     imageValid,
   // Result.
   output logic [`STRAP_WIDTH-1:0]       strapCode,
   output boot_order_pkg::boot_src_t     bootSrc,
   output logic                          bootDone,
   output logic                          bootFailed,
   output logic                          fastXipPath
);
   import boot_order_pkg::*;

   localparam int TW = $clog2(PROBE_TIMEOUT + 1);

   // Pin synchroniser; only stage two and three are compared.
   logic [`STRAP_WIDTH-1:0] sync1_ff;
   logic [`STRAP_WIDTH-1:0] sync2_ff;
   logic [`STRAP_WIDTH-1:0] sync3_ff;
   logic                    warm1_ff;
   logic                    warm2_ff;
   logic                    warm3_ff;
   logic [`STRAP_WIDTH-1:0] nxt_sync1;
   logic [`STRAP_WIDTH-1:0] nxt_sync2;
   logic [`STRAP_WIDTH-1:0] nxt_sync3;
   logic                    nxt_warm1;
   logic                    nxt_warm2;
   logic                    nxt_warm3;

   walk_state_t             state_ff;
   walk_state_t             nxt_state;
   logic [`STRAP_WIDTH-1:0] code_ff;
   logic [`STRAP_WIDTH-1:0] nxt_code;
   logic                    warm_ff;
   logic                    nxt_warm;
   logic [1:0]              slot_ff;
   logic [1:0]              nxt_slot;
   logic [TW-1:0]           timer_ff;
   logic [TW-1:0]           nxt_timer;
   boot_src_t               boot_ff;
   boot_src_t               nxt_boot;
   logic                    req_ff;
   logic                    nxt_req;
   logic                    fast_ff;
   logic                    nxt_fast;
   logic [1:0]              fill_ff;
   logic [1:0]              nxt_fill;
   logic                    srcAnswer;

   boot_src_t               tableSrc;
   logic                    tableFast;

   boot_order_table u_table (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .strapCode  (code_ff),
      .warmBoot   (warm_ff),
      .slot       (slot_ff),
      .srcOut     (tableSrc),
      .memPrefOut (tableFast)
   );

   always_comb begin
      nxt_sync1 = strapPins;
      nxt_sync2 = sync1_ff;
      nxt_sync3 = sync2_ff;
      nxt_warm1 = warmReset;
      nxt_warm2 = warm1_ff;
      nxt_warm3 = warm2_ff;
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
         warm1_ff <= 1'b0;
         warm2_ff <= 1'b0;
         warm3_ff <= 1'b0;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         sync3_ff <= nxt_sync3;
         warm1_ff <= nxt_warm1;
         warm2_ff <= nxt_warm2;
         warm3_ff <= nxt_warm3;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_code  = code_ff;
      nxt_warm  = warm_ff;
      nxt_slot  = slot_ff;
      nxt_timer = timer_ff;
      nxt_boot  = boot_ff;
      nxt_req   = 1'b0;
      nxt_fast  = fast_ff;
      nxt_fill  = fill_ff;
      unique case (state_ff)
         ST_CAPTURE: begin
            // Reset clears the stages, so they agree before any pin value
            // has reached stage three; three edges fill them first.
            if (fill_ff != 2'd3) begin
               nxt_fill = fill_ff + 2'd1;
            end else if (sync2_ff == sync3_ff && warm2_ff == warm3_ff) begin
               nxt_code  = sync3_ff;
               nxt_warm  = warm3_ff;
               nxt_slot  = 2'd0;
               nxt_state = ST_LOOKUP;
            end
         end
         ST_LOOKUP: begin
            // One cycle for the registered table answer to settle.
            nxt_state = ST_PROBE;
            nxt_timer = '0;
         end
         ST_PROBE: begin
            nxt_fast = tableFast;
            if (tableSrc == SRC_NONE) begin
               nxt_state = ST_FAILED;
            end else begin
               nxt_req   = 1'b1;
               nxt_timer = TW'(timer_ff + 1'b1);
               if (srcAnswer && imageValid) begin
                  nxt_boot  = tableSrc;
                  nxt_req   = 1'b0;
                  nxt_state = ST_BOOTED;
               end else if (srcAnswer ||
                            timer_ff == TW'(PROBE_TIMEOUT - 1)) begin
                  nxt_req = 1'b0;
                  if (slot_ff == 2'(`ORDER_SLOTS - 1)) begin
                     nxt_state = ST_FAILED;
                  end else begin
                     nxt_slot  = slot_ff + 2'd1;
                     nxt_state = ST_LOOKUP;
                  end
               end
            end
         end
         ST_BOOTED: nxt_state = ST_BOOTED;
         ST_FAILED: nxt_state = ST_FAILED;
         default:   nxt_state = ST_FAILED;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_ff <= ST_CAPTURE;
         code_ff  <= '0;
         warm_ff  <= 1'b0;
         slot_ff  <= 2'd0;
         timer_ff <= '0;
         boot_ff  <= SRC_NONE;
         req_ff   <= 1'b0;
         fast_ff  <= 1'b0;
         fill_ff  <= 2'd0;
      end else begin
         state_ff <= nxt_state;
         code_ff  <= nxt_code;
         warm_ff  <= nxt_warm;
         slot_ff  <= nxt_slot;
         timer_ff <= nxt_timer;
         boot_ff  <= nxt_boot;
         req_ff   <= nxt_req;
         fast_ff  <= nxt_fast;
         fill_ff  <= nxt_fill;
      end
   end

   assign probeReq    = req_ff && state_ff == ST_PROBE;
   assign probeSrc    = tableSrc;
   assign strapCode   = code_ff;
   assign bootSrc     = boot_ff;
   assign bootDone    = state_ff == ST_BOOTED;
   assign bootFailed  = state_ff == ST_FAILED;
   assign fastXipPath = fast_ff;
   // An answer counts only while the request stands.
   assign srcAnswer   = req_ff && probeDone;

endmodule : boot_order_strap_decoder

// file: test/boot_order_strap_decoder_properties.sv
`timescale 1ns/100ps
`include "boot_order_map.svh"

module boot_order_strap_decoder_properties #(
   parameter int PROBE_TIMEOUT = `PROBE_TIMEOUT_CYC
) (
   // Clock and reset.
   input wire logic                    core_clk,
   input wire logic                    resetn,
   // Board straps and reset kind.
   input wire logic [`STRAP_WIDTH-1:0] strapPins,
   input wire logic                    warmReset,
   // Probe handshake.
   input wire logic                    probeReq,
   input boot_order_pkg::boot_src_t    probeSrc,
   input wire logic                    probeDone,
   input wire logic                    imageValid,
   // Result.
   input wire logic [`STRAP_WIDTH-1:0] strapCode,
   input boot_order_pkg::boot_src_t    bootSrc,
   input wire logic                    bootDone,
   input wire logic                    bootFailed,
   input wire logic                    fastXipPath
);
   import boot_order_pkg::*;

   // Remembers the source that answered with a valid image.
   boot_src_t   okSrc_ff;
   boot_src_t   nxt_okSrc;
   // Counts how long the current probe request has stood.
   int unsigned reqCnt_ff;
   int unsigned nxt_reqCnt;

   always_comb begin
      nxt_okSrc  = okSrc_ff;
      nxt_reqCnt = probeReq ? reqCnt_ff + 1 : 0;
      if (probeReq && probeDone && imageValid) begin
         nxt_okSrc = probeSrc;
      end
      if (!resetn) begin
         nxt_okSrc  = SRC_NONE;
         nxt_reqCnt = 0;
      end
   end

   always_ff @(posedge core_clk) begin
      okSrc_ff  <= nxt_okSrc;
      reqCnt_ff <= nxt_reqCnt;
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   chk_quiet_start: assert property ($rose(resetn) |-> !probeReq [*3])
      else $error("probe request too soon after reset");
   chk_done_excl: assert property (!(bootDone && bootFailed))
      else $error("boot done and boot failed together");
   chk_done_holds: assert property (bootDone |=> bootDone && $stable(bootSrc))
      else $error("boot result did not hold");
   chk_stop_probe: assert property ((bootDone || bootFailed) |-> !probeReq)
      else $error("probing went on after the walk ended");
   chk_valid_boots: assert property (
      probeReq && probeDone && imageValid |-> ##[1:3] bootDone)
      else $error("valid image did not lead to boot");
   chk_boot_source: assert property (bootDone |-> bootSrc == okSrc_ff)
      else $error("boot source is not the one that answered");
   chk_invalid_advance: assert property (
      probeReq && probeDone && !imageValid |=> !probeReq && !bootDone)
      else $error("empty source did not end its probe");
   chk_src_named: assert property (probeReq |-> probeSrc != SRC_NONE)
      else $error("probe of an empty slot");
   chk_timeout_bound: assert property (reqCnt_ff <= PROBE_TIMEOUT + 3)
      else $error("probe request outlived its timeout");
   chk_fail_holds: assert property (bootFailed |=> bootFailed)
      else $error("boot failure did not hold");
   chk_code_stable: assert property (
      (bootDone || bootFailed) |=> $stable(strapCode))
      else $error("captured code changed");
   chk_fast_flag: assert property ((bootDone || bootFailed) |->
      fastXipPath == (strapCode == `STRAP_FAST_XIP))
      else $error("fast path flag does not match the code");

   cover property (bootDone && bootSrc == SRC_USB);
   cover property (bootFailed);
   cover property (probeReq && probeDone && !imageValid);
   cover property (bootDone && fastXipPath);
endmodule : boot_order_strap_decoder_properties

bind boot_order_strap_decoder boot_order_strap_decoder_properties #(
   .PROBE_TIMEOUT(PROBE_TIMEOUT)
) u_props (
   .core_clk(core_clk), .resetn(resetn), .strapPins(strapPins),
   .warmReset(warmReset), .probeReq(probeReq), .probeSrc(probeSrc),
   .probeDone(probeDone), .imageValid(imageValid), .strapCode(strapCode),
   .bootSrc(bootSrc), .bootDone(bootDone), .bootFailed(bootFailed),
   .fastXipPath(fastXipPath)
);

// file: test/boot_source_model.sv
`timescale 1ns/100ps

// Boot sources: each answers a probe after a set delay; delay 4'hF never.
module boot_source_model (
   // Clock and reset.
   input wire logic                 core_clk,
   input wire logic                 resetn,
   // Probe handshake.
   input wire logic                 probeReq,
   input boot_order_pkg::boot_src_t probeSrc,
   output logic                     probeDone,
   output logic                     imageValid,
   // Scenario control.
   input wire logic [15:0]          validMask,
   input wire logic [3:0]           answerDelay
);
   logic [3:0] waitCnt = 4'h0;
   logic       answered = 1'b0;
   logic       toggle = 1'b0;

   // Outside an answer the valid line carries a changing pattern.
   always @(posedge core_clk) begin
      toggle <= ~toggle;
      if (!resetn || !probeReq) begin
         waitCnt    <= 4'h0;
         answered   <= 1'b0;
         probeDone  <= 1'b0;
         imageValid <= toggle;
      end else if (!answered && answerDelay != 4'hF
                   && waitCnt == answerDelay) begin
         probeDone  <= 1'b1;
         imageValid <= validMask[probeSrc];
         answered   <= 1'b1;
      end else begin
         probeDone  <= 1'b0;
         imageValid <= toggle;
         waitCnt    <= waitCnt + 4'h1;
      end
   end
endmodule : boot_source_model

// file: test/testbench.sv
`timescale 1ns/100ps
`include "boot_order_map.svh"
`define CHECK(act, exp) begin \
   nChecks++; \
   if ((act) !== (exp)) begin \
      errCount++; \
      $display("mismatch at %0t: got %h expected %h", $time, (act), (exp)); \
   end \
end

module testbench;
   import boot_order_pkg::*;

   logic                    core_clk;
   logic                    resetn;
   logic [`STRAP_WIDTH-1:0] strapPins;
   logic                    warmReset;
   logic                    probeReq;
   boot_src_t               probeSrc;
   logic                    probeDone;
   logic                    imageValid;
   logic [`STRAP_WIDTH-1:0] strapCode;
   boot_src_t               bootSrc;
   logic                    bootDone;
   logic                    bootFailed;
   logic                    fastXipPath;
   logic [15:0]             validMask;
   logic [3:0]              answerDelay;
   logic [15:0]             probeLog;
   logic [2:0]              probeCount;
   logic                    reqSeen = 1'b0;
   int                      errCount = 0;
   int                      nChecks = 0;

   boot_order_strap_decoder #(.PROBE_TIMEOUT(8)) u_dut (
      .core_clk(core_clk), .resetn(resetn), .strapPins(strapPins),
      .warmReset(warmReset), .probeReq(probeReq), .probeSrc(probeSrc),
      .probeDone(probeDone), .imageValid(imageValid),
      .strapCode(strapCode), .bootSrc(bootSrc), .bootDone(bootDone),
      .bootFailed(bootFailed), .fastXipPath(fastXipPath)
   );

   boot_source_model u_src (
      .core_clk(core_clk), .resetn(resetn), .probeReq(probeReq),
      .probeSrc(probeSrc), .probeDone(probeDone), .imageValid(imageValid),
      .validMask(validMask), .answerDelay(answerDelay)
   );

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Logs each source as its probe starts, newest in the low nibble.
   always @(posedge core_clk) begin
      reqSeen <= probeReq;
      if (!resetn) begin
         probeLog   <= 16'h0000;
         probeCount <= 3'h0;
      end else if (probeReq === 1'b1 && reqSeen !== 1'b1) begin
         probeLog   <= {probeLog[11:0], probeSrc};
         probeCount <= probeCount + 3'h1;
      end
   end

   task automatic run_boot(input string name, input logic [5:0] code,
      input logic warm, input logic [15:0] mask, input logic [3:0] dly,
      input logic [15:0] expSeq, input logic [2:0] expCnt,
      input boot_src_t expSrc, input logic expFail);
      int i;
      @(posedge core_clk);
      resetn      <= 1'b0;
      strapPins   <= code;
      warmReset   <= warm;
      validMask   <= mask;
      answerDelay <= dly;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      // The pins move after capture; the captured code must not.
      repeat (10) @(posedge core_clk);
      strapPins <= ~code;
      warmReset <= ~warm;
      for (i = 0; i < 300; i++) begin
         @(negedge core_clk);
         if (bootDone === 1'b1 || bootFailed === 1'b1) break;
      end
      `CHECK(probeCount, expCnt)
      `CHECK(probeLog, expSeq)
      `CHECK(bootFailed, expFail)
      `CHECK(bootDone, ~expFail)
      `CHECK(bootSrc, expSrc)
      `CHECK(strapCode, code)
      `CHECK(fastXipPath, (code == `STRAP_FAST_XIP))
      $display("test %s done", name);
   endtask : run_boot

   task test_default_order;
      run_boot("default_order", `STRAP_DEFAULT, 1'b0, 16'h0001 << SRC_USB,
         4'h0, {SRC_NAND, SRC_ETHERNET, SRC_USB}, 3'h3, SRC_USB, 1'b0);
   endtask : test_default_order

   task test_por_codes;
      run_boot("por_01", 6'h01, 1'b0, 16'h0000, 4'h1,
         {SRC_NAND, SRC_ETHERNET, SRC_USB}, 3'h3, SRC_NONE, 1'b1);
      run_boot("por_03", 6'h03, 1'b0, 16'h0001 << SRC_CARD_TWO, 4'h2,
         {SRC_CARD_TWO}, 3'h1, SRC_CARD_TWO, 1'b0);
      run_boot("por_05", 6'h05, 1'b0, 16'h0001 << SRC_USB, 4'h0,
         {SRC_CARD_TWO, SRC_USB}, 3'h2, SRC_USB, 1'b0);
   endtask : test_por_codes

   task test_xip_order;
      run_boot("por_0d", 6'h0D, 1'b0, 16'h0001 << SRC_CARD_ONE, 4'h5,
         {SRC_XIP_FLASH, SRC_USB, SRC_UART, SRC_CARD_ONE}, 3'h4,
         SRC_CARD_ONE, 1'b0);
   endtask : test_xip_order

   task test_fast_xip;
      run_boot("fast_1f", 6'h1F, 1'b0, 16'h0001 << SRC_SERIAL_3, 4'h0,
         {SRC_XIP_WAIT, SRC_USB, SRC_SERIAL_3}, 3'h3, SRC_SERIAL_3, 1'b0);
      run_boot("fast_1f_warm", 6'h1F, 1'b1, 16'h0001 << SRC_XIP_WAIT, 4'h3,
         {SRC_XIP_WAIT}, 3'h1, SRC_XIP_WAIT, 1'b0);
   endtask : test_fast_xip

   task test_warm_table;
      run_boot("warm_21", 6'h21, 1'b1, 16'h0001 << SRC_NAND, 4'h0,
         {SRC_ETHERNET, SRC_USB, SRC_NAND}, 3'h3, SRC_NAND, 1'b0);
      run_boot("warm_3c", 6'h3C, 1'b1, 16'h0001 << SRC_SPI, 4'h1,
         {SRC_UART, SRC_SPI}, 3'h2, SRC_SPI, 1'b0);
   endtask : test_warm_table

   task test_reserved;
      run_boot("reserved_02", 6'h02, 1'b0, 16'hFFFF, 4'h0,
         16'h0000, 3'h0, SRC_NONE, 1'b1);
      run_boot("reserved_3f", 6'h3F, 1'b0, 16'hFFFF, 4'h0,
         16'h0000, 3'h0, SRC_NONE, 1'b1);
   endtask : test_reserved

   task test_timeout;
      run_boot("timeout_01", 6'h01, 1'b0, 16'hFFFF, 4'hF,
         {SRC_NAND, SRC_ETHERNET, SRC_USB}, 3'h3, SRC_NONE, 1'b1);
   endtask : test_timeout

   task print_verdict;
      $display("checks %0d mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict

   initial begin
      resetn      = 1'b0;
      strapPins   = `STRAP_DEFAULT;
      warmReset   = 1'b0;
      validMask   = 16'h0000;
      answerDelay = 4'h0;
      test_default_order();
      test_por_codes();
      test_xip_order();
      test_fast_xip();
      test_warm_table();
      test_reserved();
      test_timeout();
      print_verdict();
   end

   // About a dozen boots of under 200 cycles each fit well inside this.
   initial begin
      repeat (20000) @(posedge core_clk);
      errCount++;
      print_verdict();
   end
endmodule : testbench
